/* hdl/auto_power_pkg.sv */
/*
  Constants and carrier types for the automatic power control block.
  Assumes a 25 MHz system clock and a free-running 32.768 kHz oscillator
  level that is sampled as an ordinary synchronous input.
*/
package auto_power_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_CTRL_ONE   = 8'h40;
  localparam logic [7:0] IDX_CTRL_TWO   = 8'h41;
  localparam logic [7:0] IDX_STATUS     = 8'h42;
  localparam logic [7:0] IDX_WAKE_DOW   = 8'h43;
  localparam logic [7:0] IDX_WAKE_DATE  = 8'h44;
  localparam logic [7:0] IDX_WAKE_MONTH = 8'h45;
  localparam logic [7:0] IDX_WAKE_YEAR  = 8'h46;
  localparam logic [7:0] IDX_RAM_LOCK   = 8'h47;
  localparam logic [7:0] IDX_WAKE_CENT  = 8'h48;

  // Field positions
  localparam int SOFT_OFF_BIT   = 5;
  localparam int LOST_BIT       = 7;
  localparam int TIME_EN_BIT    = 0;
  localparam int TRAIN_BIT      = 2;
  localparam int RING_EN_BIT    = 3;
  localparam int TIME_SEEN_BIT  = 0;
  localparam int RING_SEEN_BIT  = 1;
  localparam int PIN_LEVEL_BIT  = 7;
  localparam int UPPER_PORT_BIT = 3;
  localparam int UPPER_RD_BIT   = 4;
  localparam int UPPER_WR_BIT   = 5;
  localparam int WRITE_MASK_BIT = 6;
  localparam int WINDOW_BIT     = 7;

  // Writable masks and values after first power
  localparam logic [7:0] CTRL_TWO_MASK = 8'h0d;
  localparam logic [7:0] LOCK_MASK     = 8'hf8;
  localparam logic [7:0] CTRL_INIT     = 8'h00;
  localparam logic [7:0] FF_BYTE       = 8'hff;

  // RAM windows
  localparam logic [6:0] GP_LOW_FIRST  = 7'h0e;
  localparam logic [6:0] BANK0_HIGH    = 7'h40;
  localparam logic [6:0] WINDOW_FIRST  = 7'h38;
  localparam logic [6:0] WINDOW_LAST   = 7'h3f;
  localparam logic [6:0] UPPER_LOW_END = 7'h1f;

  // Timing in oscillator ticks
  localparam int OSC_HZ        = 32768;
  localparam int BLANK_MS      = 1000;
  localparam int SLOT_US       = 62500;
  localparam int BLANK_TICKS   = OSC_HZ * BLANK_MS / 1000;
  localparam int SLOT_TICKS    = OSC_HZ * SLOT_US / 1000000;
  localparam logic [3:0] TRAIN_PATTERN = 4'h7;

  // Current time or alarm set, one byte per field
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] dow;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } calendar_t;

  // RAM access request from the RTC register file
  typedef struct packed {
    logic       upper;
    logic [1:0] bank;
    logic [6:0] addr;
  } ram_access_t;

  // RAM access verdict
  typedef struct packed {
    logic write_block;
    logic read_ff;
  } ram_verdict_t;

endpackage

/* hdl/auto_power_ctrl.sv */
/*
  Automatic power control: wake and off request pulses, date match,
  ring pulse and pulse-train detection, power-loss blanking and RAM lock.
  Assumes a classic Wishbone master, a 25 MHz mclk, the 32.768 kHz
  oscillator level on osc_32k, and the calendar supplied by the RTC core.
*/
// Notes on behaviour
// - Wake and off requests are pulses
// - Enabled date match pulses wake request
// - Enabled ring detection pulses wake request
// - Soft off write pulses off request
// - Wake requests only after one second
// - Ring masked high until one second
// - Match during power off is remembered
// - Earlier events still wake after power loss
// - Eight wake fields compared with calendar
// - Train: three edge slots after empty
// - Controls cleared only by first power
// - Supply lost flag sets, write-one clears
// - Status read clears event bits
// - Time seen bit ignores enable
// - Ring seen bit ignores enable
// - Status bit seven shows ring pin, held high while off and blanking
// - Lock bits stay until master reset or first power
// - Upper port blocked, reads all ones
// - Upper bytes 00h-1Fh read all ones
// - Upper bytes 00h-1Fh writes discarded
// - Write mask covers general RAM
// - Window 38h-3Fh blocked, reads ones
`timescale 1ns/1ps
`default_nettype none

module auto_power_ctrl (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      first_power,
  input  wire logic                      hardware_master_reset_pin,
  input  wire logic                      main_power_ok,
  input  wire logic                      osc_32k,
  input  wire logic                      ring_n,
  input  wire auto_power_pkg::calendar_t now_time,
  input  wire logic [7:0]                alarm_second,
  input  wire logic [7:0]                alarm_minute,
  input  wire logic [7:0]                alarm_hour,
  input  wire auto_power_pkg::ram_access_t ram_access,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [9:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           wake_request_pulse,
  output logic                           off_request_pulse,
  output auto_power_pkg::ram_verdict_t   ram_verdict
);

  typedef enum logic [2:0] {
    PWR_ON    = 3'h1,
    PWR_OFF   = 3'h2,
    PWR_BLANK = 3'h4
  } power_state_t;

  typedef struct packed {
    power_state_t pstate;
    logic [7:0]   ctrl_one;
    logic [7:0]   ctrl_two;
    logic [7:0]   lock;
    logic [7:0]   wake_dow;
    logic [7:0]   wake_date;
    logic [7:0]   wake_month;
    logic [7:0]   wake_year;
    logic [7:0]   wake_cent;
    logic         time_seen;
    logic         ring_seen;
    logic         pend_time;
    logic         pend_ring;
    logic         match_last;
    logic [2:0]   osc_sync;
    logic [1:0]   ring_sync;
    logic         ring_last;
    logic [15:0]  blank_cnt;
    logic [11:0]  slot_cnt;
    logic         slot_edge;
    logic [3:0]   slot_hist;
    logic         ack;
    logic [31:0]  rdata;
    logic         wake;
    logic         off;
    auto_power_pkg::ram_verdict_t verdict;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // RAM lock decode, shared by the read and write verdicts
  function automatic auto_power_pkg::ram_verdict_t lock_decode(
    input logic [7:0]                  lk,
    input auto_power_pkg::ram_access_t acc
  );
    auto_power_pkg::ram_verdict_t v;
    logic in_window;
    logic upper_low;
    in_window = !acc.upper && acc.addr >= auto_power_pkg::WINDOW_FIRST
                && acc.addr <= auto_power_pkg::WINDOW_LAST;
    upper_low = acc.upper && acc.addr <= auto_power_pkg::UPPER_LOW_END;
    v.read_ff = (acc.upper && lk[auto_power_pkg::UPPER_PORT_BIT])
              || (upper_low && lk[auto_power_pkg::UPPER_RD_BIT])
              || (in_window && lk[auto_power_pkg::WINDOW_BIT]);
    v.write_block = (acc.upper && lk[auto_power_pkg::UPPER_PORT_BIT])
              || (upper_low && lk[auto_power_pkg::UPPER_WR_BIT])
              || (in_window && lk[auto_power_pkg::WINDOW_BIT])
              || (lk[auto_power_pkg::WRITE_MASK_BIT]
                  && (acc.upper
                      || (acc.addr >= auto_power_pkg::GP_LOW_FIRST && acc.addr < auto_power_pkg::BANK0_HIGH)
                      || (acc.bank == 2'h0 && acc.addr >= auto_power_pkg::BANK0_HIGH)));
    return v;
  endfunction

  logic        bus_req;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic        tick;
  logic        ring_level;
  logic        ring_fall;
  logic        time_match;
  logic        match_rise;
  logic        ring_detect;
  logic        slot_end;
  logic [3:0]  hist_new;
  logic        blank_done;

  // Bus decode: only byte lane 0 carries register data
  assign bus_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign wr_hit  = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_hit  = bus_req && !wb_we_i;
  assign idx     = wb_adr_i[9:2];
  assign wbyte   = wb_dat_i[7:0];

  // Oscillator edge from the synchronised level; first stage feeds only the second
  assign tick = state_reg.osc_sync[1] && !state_reg.osc_sync[2];

  // Ring pin held inactive high while off and during the blanking second
  assign ring_level = (state_reg.pstate == PWR_ON) ? state_reg.ring_sync[1] : 1'b1;
  assign ring_fall  = tick && state_reg.ring_last && !ring_level;

  // All eight fields must agree at once
  assign time_match = now_time == {state_reg.wake_cent, state_reg.wake_year,
                                   state_reg.wake_month, state_reg.wake_date,
                                   state_reg.wake_dow, alarm_hour,
                                   alarm_minute, alarm_second};
  assign match_rise = time_match && !state_reg.match_last;

  // Slot history: newest slot in bit 0
  assign slot_end   = tick && state_reg.slot_cnt == 12'(auto_power_pkg::SLOT_TICKS - 1);
  assign hist_new   = {state_reg.slot_hist[2:0], state_reg.slot_edge || ring_fall};
  assign ring_detect = state_reg.ctrl_two[auto_power_pkg::TRAIN_BIT]
                       ? (slot_end && hist_new == auto_power_pkg::TRAIN_PATTERN)
                       : ring_fall;
  assign blank_done = tick && state_reg.blank_cnt == 16'(auto_power_pkg::BLANK_TICKS - 1);

  // Next-state logic for the whole block
  always_comb
  begin
    state_next = state_reg;
    state_next.osc_sync  = {state_reg.osc_sync[1:0], osc_32k};
    state_next.ring_sync = {state_reg.ring_sync[0], ring_n};
    state_next.match_last = time_match;
    state_next.wake = 1'b0;
    state_next.off  = 1'b0;
    state_next.ack  = bus_req;
    state_next.verdict = lock_decode(state_reg.lock, ram_access);

    if (tick)
    begin
      state_next.ring_last = ring_level;
    end

    // Ring slot timing from the oscillator divider
    if (tick)
    begin
      state_next.slot_cnt = slot_end ? 12'h000 : state_reg.slot_cnt + 12'h001;
      state_next.slot_edge = slot_end ? 1'b0 : (state_reg.slot_edge || ring_fall);
    end
    if (slot_end)
    begin
      state_next.slot_hist = hist_new;
    end

    // Power state: off on main supply loss, one blanking second on return
    case (state_reg.pstate)
      PWR_ON:
      begin
        if (!main_power_ok)
        begin
          state_next.pstate = PWR_OFF;
          state_next.ctrl_one[auto_power_pkg::LOST_BIT] = 1'b1;
        end
      end
      PWR_OFF:
      begin
        state_next.blank_cnt = 16'h0000;
        if (main_power_ok)
        begin
          state_next.pstate = PWR_BLANK;
        end
      end
      PWR_BLANK:
      begin
        if (!main_power_ok)
        begin
          state_next.pstate = PWR_OFF;
          state_next.ctrl_one[auto_power_pkg::LOST_BIT] = 1'b1;
        end
        else if (blank_done)
        begin
          state_next.pstate = PWR_ON;
        end
        else if (tick)
        begin
          state_next.blank_cnt = state_reg.blank_cnt + 16'h0001;
        end
      end
      default:
      begin
        state_next.pstate = PWR_OFF;
      end
    endcase

    // Status and pending wake: a clear by read loses to a same-cycle set
    if (rd_hit && idx == auto_power_pkg::IDX_STATUS)
    begin
      state_next.time_seen = 1'b0;
      state_next.ring_seen = 1'b0;
    end
    if (match_rise)
    begin
      state_next.time_seen = 1'b1;
    end
    if (ring_detect)
    begin
      state_next.ring_seen = 1'b1;
    end

    // Soft off drops earlier events; later events survive a power loss
    if (wr_hit && idx == auto_power_pkg::IDX_CTRL_ONE && wbyte[auto_power_pkg::SOFT_OFF_BIT])
    begin
      state_next.off = 1'b1;
      state_next.pend_time = 1'b0;
      state_next.pend_ring = 1'b0;
    end
    if (match_rise && state_reg.ctrl_two[auto_power_pkg::TIME_EN_BIT])
    begin
      state_next.pend_time = 1'b1;
    end
    if (ring_detect && state_reg.ctrl_two[auto_power_pkg::RING_EN_BIT])
    begin
      state_next.pend_ring = 1'b1;
    end

    // One pulse per batch of pending events, only with power on and blanking over
    if (state_reg.pstate == PWR_ON && (state_reg.pend_time || state_reg.pend_ring))
    begin
      state_next.wake = 1'b1;
      state_next.pend_time = match_rise && state_reg.ctrl_two[auto_power_pkg::TIME_EN_BIT];
      state_next.pend_ring = ring_detect && state_reg.ctrl_two[auto_power_pkg::RING_EN_BIT];
    end

    // Register writes; the soft-off bit is never stored
    if (wr_hit)
    begin
      case (idx)
        auto_power_pkg::IDX_CTRL_ONE:
        begin
          if (wbyte[auto_power_pkg::LOST_BIT] && state_next.pstate == state_reg.pstate)
          begin
            state_next.ctrl_one[auto_power_pkg::LOST_BIT] = 1'b0;
          end
        end
        auto_power_pkg::IDX_CTRL_TWO:   state_next.ctrl_two = wbyte & auto_power_pkg::CTRL_TWO_MASK;
        auto_power_pkg::IDX_WAKE_DOW:   state_next.wake_dow = wbyte;
        auto_power_pkg::IDX_WAKE_DATE:  state_next.wake_date = wbyte;
        auto_power_pkg::IDX_WAKE_MONTH: state_next.wake_month = wbyte;
        auto_power_pkg::IDX_WAKE_YEAR:  state_next.wake_year = wbyte;
        auto_power_pkg::IDX_WAKE_CENT:  state_next.wake_cent = wbyte;
        auto_power_pkg::IDX_RAM_LOCK:
        begin
          state_next.lock = state_reg.lock | (wbyte & auto_power_pkg::LOCK_MASK);
        end
        default:                        state_next.lock = state_reg.lock;
      endcase
    end

    // Read data; unmapped addresses read zero
    state_next.rdata = 32'h0000_0000;
    if (rd_hit)
    begin
      case (idx)
        auto_power_pkg::IDX_CTRL_ONE:
          state_next.rdata[7:0] = state_reg.ctrl_one & 8'h80;
        auto_power_pkg::IDX_CTRL_TWO:   state_next.rdata[7:0] = state_reg.ctrl_two;
        auto_power_pkg::IDX_STATUS:
          state_next.rdata[7:0] = {ring_level, 5'h00, state_reg.ring_seen, state_reg.time_seen};
        auto_power_pkg::IDX_WAKE_DOW:   state_next.rdata[7:0] = state_reg.wake_dow;
        auto_power_pkg::IDX_WAKE_DATE:  state_next.rdata[7:0] = state_reg.wake_date;
        auto_power_pkg::IDX_WAKE_MONTH: state_next.rdata[7:0] = state_reg.wake_month;
        auto_power_pkg::IDX_WAKE_YEAR:  state_next.rdata[7:0] = state_reg.wake_year;
        auto_power_pkg::IDX_RAM_LOCK:   state_next.rdata[7:0] = state_reg.lock;
        auto_power_pkg::IDX_WAKE_CENT:  state_next.rdata[7:0] = state_reg.wake_cent;
        default:                        state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Master reset pin and first power are the only ways to drop lock bits
    if (hardware_master_reset_pin)
    begin
      state_next.lock = auto_power_pkg::CTRL_INIT;
    end

    // First power clears all persistent control state
    if (first_power)
    begin
      state_next.ctrl_one   = auto_power_pkg::CTRL_INIT;
      state_next.ctrl_two   = auto_power_pkg::CTRL_INIT;
      state_next.lock       = auto_power_pkg::CTRL_INIT;
      state_next.wake_dow   = auto_power_pkg::CTRL_INIT;
      state_next.wake_date  = auto_power_pkg::CTRL_INIT;
      state_next.wake_month = auto_power_pkg::CTRL_INIT;
      state_next.wake_year  = auto_power_pkg::CTRL_INIT;
      state_next.wake_cent  = auto_power_pkg::CTRL_INIT;
      state_next.time_seen  = 1'b0;
      state_next.ring_seen  = 1'b0;
      state_next.pend_time  = 1'b0;
      state_next.pend_ring  = 1'b0;
    end
  end

  // System reset leaves control registers and pending events alone
  always_ff @(posedge mclk)
  begin
    state_reg <= state_next;
    if (!rst_n)
    begin
      state_reg.pstate    <= PWR_OFF;
      state_reg.osc_sync  <= 3'h0;
      state_reg.ring_sync <= 2'h3;
      state_reg.ring_last <= 1'b1;
      state_reg.blank_cnt <= 16'h0000;
      state_reg.slot_cnt  <= 12'h000;
      state_reg.slot_edge <= 1'b0;
      state_reg.slot_hist <= 4'hf;
      state_reg.ack       <= 1'b0;
      state_reg.rdata     <= 32'h0000_0000;
      state_reg.wake      <= 1'b0;
      state_reg.off       <= 1'b0;
      state_reg.verdict   <= '0;
      state_reg.match_last <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o           = state_reg.rdata;
  assign wb_ack_o           = state_reg.ack;
  assign wake_request_pulse = state_reg.wake;
  assign off_request_pulse  = state_reg.off;
  assign ram_verdict        = state_reg.verdict;

endmodule

`default_nettype wire

/* dv/auto_power_ctrl_chk.sv */
/*
  Checker for auto_power_ctrl: request pulses, soft off, blanking, lock verdicts.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module auto_power_ctrl_chk (
  input wire logic                         mclk,
  input wire logic                         rst_n,
  input wire logic                         first_power,
  input wire logic                         hardware_master_reset_pin,
  input wire logic                         main_power_ok,
  input wire logic                         osc_32k,
  input wire auto_power_pkg::ram_access_t  ram_access,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [9:0]                   wb_adr_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [31:0]                  wb_dat_i,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic                         wake_request_pulse,
  input wire logic                         off_request_pulse,
  input wire auto_power_pkg::ram_verdict_t ram_verdict
);
  logic [7:0]  lock_reg;
  logic [15:0] ticks_reg;
  logic        osc_reg;
  logic        soc1_reg;
  logic        soc2_reg;
  wire logic       take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic       wr0 = take && wb_we_i && wb_sel_i[0];
  wire logic [7:0] idx = wb_adr_i[9:2];
  wire logic [6:0] ra = ram_access.addr;

  // Lock shadow and oscillator tick count since main power came back
  always_ff @(posedge mclk)
  begin
    osc_reg <= osc_32k;
    soc1_reg <= wr0 && idx == 8'h40 && wb_dat_i[5];
    soc2_reg <= soc1_reg;
    if (first_power || hardware_master_reset_pin)
      lock_reg <= 8'h00;
    else if (wr0 && idx == 8'h47)
      lock_reg <= lock_reg | (wb_dat_i[7:0] & 8'hf8);
    if (!rst_n || !main_power_ok)
      ticks_reg <= 16'h0000;
    else if (osc_32k && !osc_reg && ticks_reg != 16'hffff)
      ticks_reg <= ticks_reg + 16'h0001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_wake_pulse;
    wake_request_pulse |=> !wake_request_pulse;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request longer than one cycle");
  property p_off_pulse;
    off_request_pulse |=> !off_request_pulse;
  endproperty
  a_off_pulse: assert property (p_off_pulse)
    else $error("off request longer than one cycle");
  property p_off_cause;
    off_request_pulse |-> soc1_reg || soc2_reg;
  endproperty
  a_off_cause: assert property (p_off_cause)
    else $error("off request without soft off write");
  property p_off_soon;
    soc1_reg |-> ##[0:1] off_request_pulse;
  endproperty
  a_off_soon: assert property (p_off_soon)
    else $error("soft off write gave no off request");
  property p_soc_read;
    wb_ack_o && $past(take && !wb_we_i && idx == 8'h40) |-> !wb_dat_o[5];
  endproperty
  a_soc_read: assert property (p_soc_read)
    else $error("soft off bit read back as one");
  // One tick of slack for the oscillator edge detector phase
  property p_blank;
    wake_request_pulse |-> ticks_reg >= 16'd32767;
  endproperty
  a_blank: assert property (p_blank)
    else $error("wake request inside blanking second");
  property p_window;
    $past(rst_n && !ram_access.upper && ra >= 7'h38 && ra <= 7'h3f && lock_reg[7]) |-> ram_verdict == 2'b11;
  endproperty
  a_window: assert property (p_window)
    else $error("locked window not blocked");
  property p_upper;
    $past(rst_n && ram_access.upper && lock_reg[3]) |-> ram_verdict == 2'b11;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper port not blocked");
  property p_mask;
    $past(rst_n && lock_reg[6] && (ram_access.upper || (ra >= 7'h0e && ra <= 7'h3f)
      || (ra >= 7'h40 && ram_access.bank == 2'h0))) |-> ram_verdict.write_block;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked write not blocked");

  c_wake: cover property (wake_request_pulse);
  c_off: cover property (off_request_pulse);
  c_ff: cover property (ram_verdict.read_ff);
endmodule

bind auto_power_ctrl auto_power_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .first_power(first_power),
  .hardware_master_reset_pin(hardware_master_reset_pin), .main_power_ok(main_power_ok), .osc_32k(osc_32k),
  .ram_access(ram_access), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wake_request_pulse(wake_request_pulse), .off_request_pulse(off_request_pulse), .ram_verdict(ram_verdict));
`default_nettype wire

/* dv/wakeup_unit_model.sv */
/*
  Wake-up unit model: counts wake and off request pulses.
  Assumes the requests are sampled on the block's own clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wakeup_unit_model (
  input  wire logic mclk,
  input  wire logic wake_request_pulse,
  input  wire logic off_request_pulse,
  output int        wake_count,
  output int        off_count,
  output logic      width_bad
);
  logic wake_reg = 1'b0;
  logic off_reg = 1'b0;

  initial
  begin
    wake_count = 0;
    off_count = 0;
    width_bad = 1'b0;
  end

  // Every high cycle counts, so a stretched pulse is seen twice and flagged
  always @(posedge mclk)
  begin
    wake_reg <= wake_request_pulse;
    off_reg <= off_request_pulse;
    if (wake_request_pulse === 1'b1)
      wake_count <= wake_count + 1;
    if (off_request_pulse === 1'b1)
      off_count <= off_count + 1;
    if ((wake_request_pulse && wake_reg) || (off_request_pulse && off_reg))
      width_bad <= 1'b1;
  end
endmodule
`default_nettype wire

/* dv/auto_power_ctrl_tb_top.sv */
/*
  Testbench for auto_power_ctrl: registers, power loss, wake sources, soft off, lock.
  Assumes the design, its package, the bound checker and the wake-up unit model.
*/
`timescale 1ns/1ps
`default_nettype none
module auto_power_ctrl_tb_top;
  logic                         mclk = 1'b0;
  logic                         rst_n = 1'b0;
  logic                         first_power = 1'b1;
  logic                         mrst = 1'b0;
  logic                         main_ok = 1'b1;
  logic                         osc = 1'b0;
  logic                         ring_n = 1'b1;
  logic [7:0]                   alarm_s = 8'h01;
  auto_power_pkg::ram_access_t  acc = '0;
  logic                         cyc = 1'b0;
  logic                         stb = 1'b0;
  logic                         we = 1'b0;
  logic [9:0]                   adr = '0;
  logic [3:0]                   sel = '0;
  logic [31:0]                  dw = '0;
  logic [31:0]                  dr;
  logic                         ack;
  logic                         wake;
  logic                         off;
  auto_power_pkg::ram_verdict_t verd;
  int                           wake_n;
  int                           off_n;
  logic                         wbad;
  logic [31:0]                  rd;
  int                           err_count = 0;
  int                           checked = 0;
  logic [9:0]                   tab_acc [4] = '{10'h205, 10'h038, 10'h045, 10'h090};
  logic [1:0]                   tab_v [4] = '{2'h3, 2'h3, 2'h2, 2'h2};

  auto_power_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .first_power(first_power),
    .hardware_master_reset_pin(mrst), .main_power_ok(main_ok), .osc_32k(osc), .ring_n(ring_n),
    .now_time(64'h2024011503123000), .alarm_second(alarm_s), .alarm_minute(8'h30), .alarm_hour(8'h12),
    .ram_access(acc), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wake_request_pulse(wake), .off_request_pulse(off),
    .ram_verdict(verd));
  wakeup_unit_model u_model (.mclk(mclk), .wake_request_pulse(wake), .off_request_pulse(off),
    .wake_count(wake_n), .off_count(off_n), .width_bad(wbad));

  // Oscillator runs at half the bus clock so the blanking second stays short
  always #20 mclk = ~mclk;
  always @(posedge mclk) osc <= ~osc;

  task final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h1;
    dw <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      err_count++;
      final_report();
    end
  endtask

  task rchk(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task t_regs;
    rchk(8'h40, 8'h00);
    rchk(8'h41, 8'h00);
    bus(1'b1, 8'h41, 8'hff);
    rchk(8'h41, 8'h0d);
    rchk(8'h3f, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(8'h41, 8'h0d);
    $display("regs done");
  endtask

  task t_off_match;
    int n;
    int w;
    main_ok <= 1'b0;
    ring_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rchk(8'h40, 8'h80);
    bus(1'b1, 8'h40, 8'h00);
    rchk(8'h40, 8'h80);
    bus(1'b1, 8'h40, 8'h80);
    rchk(8'h40, 8'h00);
    rchk(8'h42, 8'h80);
    ring_n <= 1'b1;
    bus(1'b1, 8'h41, 8'h01);
    bus(1'b1, 8'h43, 8'h03);
    bus(1'b1, 8'h44, 8'h15);
    bus(1'b1, 8'h45, 8'h01);
    bus(1'b1, 8'h46, 8'h24);
    bus(1'b1, 8'h48, 8'h20);
    rchk(8'h42, 8'h80);
    alarm_s <= 8'h00;
    repeat (4) @(posedge mclk);
    rchk(8'h42, 8'h81);
    rchk(8'h42, 8'h80);
    main_ok <= 1'b1;
    w = wake_n;
    n = 0;
    while (wake_n == w && n < 80000)
    begin
      @(posedge mclk);
      n++;
    end
    chk(32'(wake_n - w), 32'h1);
    chk(32'(n > 60000), 32'h1);
    if (n >= 80000)
      final_report();
    $display("power loss done");
  endtask

  task t_train;
    int w;
    bus(1'b1, 8'h41, 8'h0c);
    w = wake_n;
    for (int i = 0; i < 17; i++)
    begin
      if (i == 8)
        chk(32'(wake_n - w), 32'h0);
      ring_n <= 1'b0;
      repeat (100) @(posedge mclk);
      ring_n <= 1'b1;
      repeat (900) @(posedge mclk);
    end
    chk(32'(wake_n - w), 32'h1);
    rchk(8'h42, 8'h82);
    $display("train done");
  endtask

  task t_ring;
    int w;
    for (int en = 1; en >= 0; en--)
    begin
      bus(1'b1, 8'h41, en ? 8'h08 : 8'h00);
      w = wake_n;
      ring_n <= 1'b0;
      repeat (40) @(posedge mclk);
      rchk(8'h42, 8'h02);
      chk(32'(wake_n - w), 32'(en));
      ring_n <= 1'b1;
      repeat (40) @(posedge mclk);
    end
    $display("ring done");
  endtask

  task t_soft_off;
    int o;
    o = off_n;
    bus(1'b1, 8'h40, 8'h20);
    repeat (4) @(posedge mclk);
    chk(32'(off_n - o), 32'h1);
    rchk(8'h40, 8'h00);
    bus(1'b1, 8'h40, 8'h00);
    repeat (4) @(posedge mclk);
    chk(32'(off_n - o), 32'h1);
    $display("soft off done");
  endtask

  task t_lock;
    acc <= 10'h038;
    repeat (2) @(posedge mclk);
    chk(32'(verd), 32'h0);
    bus(1'b1, 8'h47, 8'h80);
    repeat (2) @(posedge mclk);
    chk(32'(verd), 32'h3);
    bus(1'b1, 8'h47, 8'h00);
    rchk(8'h47, 8'h80);
    bus(1'b1, 8'h47, 8'hff);
    rchk(8'h47, 8'hf8);
    for (int k = 0; k < 4; k++)
    begin
      acc <= tab_acc[k];
      repeat (2) @(posedge mclk);
      chk(32'(verd), 32'(tab_v[k]));
    end
    mrst <= 1'b1;
    @(posedge mclk);
    mrst <= 1'b0;
    rchk(8'h47, 8'h00);
    $display("lock done");
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    first_power <= 1'b0;
    t_regs();
    t_off_match();
    t_train();
    t_ring();
    t_soft_off();
    t_lock();
    chk(32'(wbad), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
